/* File: hdl/clock_switch_params.svh */
// constants for the glitch-free clock selector: register map, field
// positions, reset values and timing counts
// assumes a 20 MHz pclk and 32-bit APB data with one word per register
`ifndef CLOCK_SWITCH_PARAMS_SVH
`define CLOCK_SWITCH_PARAMS_SVH

// register byte addresses
`define ADDR_W 12
`define CTRL_ADDR 12'h000
`define STATUS_ADDR 12'h004

// control word fields
`define CTRL_SELECT_BIT 0
`define CTRL_FORCE_BIT 1
`define CTRL_GATE_EN_BIT 2
`define CTRL_GATE_LEVEL_BIT 3
`define CTRL_POWER_DOWN_N_BIT 4

// control reset values: input a, no force, outputs enabled, running
`define SELECT_RESET 1'b0
`define FORCE_RESET 1'b0
`define GATE_EN_RESET 1'b1
`define GATE_LEVEL_RESET 1'b0
`define POWER_DOWN_N_RESET 1'b1

// status word fields
`define STAT_ACTIVE_BIT 0
`define STAT_DRAIN_BIT 1
`define STAT_PARK_BIT 2
`define STAT_CLK_BIT 3
`define STAT_ALIVE_A_BIT 4
`define STAT_ALIVE_B_BIT 5

// switchover bounds, in cycles of the input clocks
`define DRAIN_MAX_CYCLES 2'h3
`define PARK_MAX_CYCLES 2'h3

// an input with no edge for this long is reported dead
`define PCLK_PERIOD_NS 50
`define DEAD_TIME_NS 1000
`define DEAD_CYCLES ((`DEAD_TIME_NS + `PCLK_PERIOD_NS - 1) / `PCLK_PERIOD_NS)

`endif

/* File: hdl/clock_switch_pkg.sv */
// types shared by the clock selector and its input samplers
// assumes nothing beyond the compile order: before the modules
package clock_switch_pkg;

    // switchover sequencer states
    typedef enum logic [1:0] {SW_RUN, SW_DRAIN, SW_PARK} switch_state_e;

    // small edge counter for drain and park phases
    typedef logic [1:0] cycle_cnt_t;

    // idle counter for the activity watchdog
    typedef logic [5:0] idle_cnt_t;

endpackage

/* File: hdl/clock_edge_sync.sv */
// samples one input clock into pclk: two-flop synchroniser, edge pulses
// and an activity watchdog
// assumes the input clock is well below half of pclk
`timescale 1ns/10ps
`include "clock_switch_params.svh"

module clock_edge_sync (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_raw,
    output logic level,
    output logic rise,
    output logic fall,
    output logic alive
);

    logic sync1_ff, sync2_ff, level_ff, rise_ff, fall_ff, alive_ff;
    logic nxt_rise, nxt_fall, nxt_alive;
    clock_switch_pkg::idle_cnt_t idle_ff, nxt_idle;

    ////////////////////////////////////////////////////////////////////////
    // edges seen on the second flop only; the first one is metastable
    always_comb begin
        nxt_rise = sync2_ff & ~level_ff;
        nxt_fall = ~sync2_ff & level_ff;
        nxt_idle = idle_ff;
        if (nxt_rise | nxt_fall) begin
            nxt_idle = '0;
        end else if (idle_ff != 6'(`DEAD_CYCLES)) begin
            nxt_idle = idle_ff + 6'h01; // saturates at the dead limit
        end
        nxt_alive = (nxt_idle != 6'(`DEAD_CYCLES));
    end

    // registers only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_ff <= 1'b0;
            sync2_ff <= 1'b0;
            level_ff <= 1'b0;
            rise_ff <= 1'b0;
            fall_ff <= 1'b0;
            idle_ff <= '0;
            alive_ff <= 1'b0;
        end else begin
            sync1_ff <= clk_raw;
            sync2_ff <= sync1_ff;
            level_ff <= sync2_ff;
            rise_ff <= nxt_rise;
            fall_ff <= nxt_fall;
            idle_ff <= nxt_idle;
            alive_ff <= nxt_alive;
        end
    end

    assign level = level_ff;
    assign rise = rise_ff;
    assign fall = fall_ff;
    assign alive = alive_ff;

endmodule

/* File: hdl/clock_switch.sv */
// glitch-free two-input clock selector with forced select, output gating
// and power-down, all controls in an APB register file
// assumes input clocks are slow enough to be oversampled by pclk; the
// output pair is a pclk-timed copy of the selected input
// limitation: output edges move by up to one pclk, and input levels
// shorter than one pclk period can be missed
//
// Functional notes
// - on a select change, park output low at its falling edge within three cycles
// - stay parked at most three new-clock cycles, resume on a new rising edge
// - selected input dead: controller toggles select and forces; output restarts
// - unselected input dead: controller forces select; output restarts on chosen input
// - while forced and running, a select change waits; the old input drives the output until force is released
// - force assertion drives the output low at once, then restarts on selected input
// - in power-down both output legs are pulled high, zero differential
// - gated-off outputs sit at the level chosen by gate level
//
// Register access over APB and the register offsets were left to the implementer.
`timescale 1ns/10ps
`include "clock_switch_params.svh"

module clock_switch (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic clk_in_a,
    input wire logic clk_in_b,
    output logic clock_output_pair_p,
    output logic clock_output_pair_n
);

    ////////////////////////////////////////////////////////////////////////
    // helpers

    // true when the bus address hits a register word
    function automatic logic reg_hit(input logic [`ADDR_W-1:0] addr,
                                     input logic [`ADDR_W-1:0] offs);
        reg_hit = (addr == offs);
    endfunction

    // picks the signal of input b when sel is high
    function automatic logic pick(input logic sel, input logic a, input logic b);
        pick = sel ? b : a;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // input samplers

    logic lvl_a, rise_a, fall_a, alive_a;
    logic lvl_b, rise_b, fall_b, alive_b;

    // one sampler per input; drain and park counts are in their edges
    clock_edge_sync sync_a (
        .pclk(pclk),
        .presetn(presetn),
        .clk_raw(clk_in_a),
        .level(lvl_a),
        .rise(rise_a),
        .fall(fall_a),
        .alive(alive_a)
    );

    clock_edge_sync sync_b (
        .pclk(pclk),
        .presetn(presetn),
        .clk_raw(clk_in_b),
        .level(lvl_b),
        .rise(rise_b),
        .fall(fall_b),
        .alive(alive_b)
    );

    ////////////////////////////////////////////////////////////////////////
    // apb slave and control register

    logic pready_ff, pslverr_ff, nxt_pready, nxt_pslverr;
    logic [31:0] prdata_ff, nxt_prdata;
    logic select_ff, force_ff, gate_en_ff, gate_level_ff, power_down_n_ff;
    logic nxt_select, nxt_force, nxt_gate_en, nxt_gate_level, nxt_power_down_n;
    logic setup_phase, access_done, addr_ok;
    logic [31:0] ctrl_word, status_word;

    // sequencer state declared here because the status word reads it
    clock_switch_pkg::switch_state_e state_ff, nxt_state;
    logic active_ff, clk_ff;

    // words as software sees them; unused bits read zero
    always_comb begin
        ctrl_word = 32'h0000_0000;
        ctrl_word[`CTRL_SELECT_BIT] = select_ff;
        ctrl_word[`CTRL_FORCE_BIT] = force_ff;
        ctrl_word[`CTRL_GATE_EN_BIT] = gate_en_ff;
        ctrl_word[`CTRL_GATE_LEVEL_BIT] = gate_level_ff;
        ctrl_word[`CTRL_POWER_DOWN_N_BIT] = power_down_n_ff;
        status_word = 32'h0000_0000;
        status_word[`STAT_ACTIVE_BIT] = active_ff;
        status_word[`STAT_DRAIN_BIT] = (state_ff == clock_switch_pkg::SW_DRAIN);
        status_word[`STAT_PARK_BIT] = (state_ff == clock_switch_pkg::SW_PARK);
        status_word[`STAT_CLK_BIT] = clk_ff;
        status_word[`STAT_ALIVE_A_BIT] = alive_a;
        status_word[`STAT_ALIVE_B_BIT] = alive_b;
    end

    // answer is prepared in the setup cycle so every bus output is a flop;
    // costs nothing, the access phase still ends after one cycle
    always_comb begin
        setup_phase = psel & ~penable;
        access_done = psel & penable & pready_ff;
        addr_ok = reg_hit(paddr, `CTRL_ADDR) | reg_hit(paddr, `STATUS_ADDR);
        nxt_pready = setup_phase;
        nxt_pslverr = setup_phase & ~addr_ok; // unmapped address
        nxt_prdata = prdata_ff;
        if (setup_phase) begin
            nxt_prdata = 32'h0000_0000;
            if (!pwrite && reg_hit(paddr, `CTRL_ADDR)) begin
                nxt_prdata = ctrl_word;
            end else if (!pwrite && reg_hit(paddr, `STATUS_ADDR)) begin
                nxt_prdata = status_word;
            end
        end
        nxt_select = select_ff;
        nxt_force = force_ff;
        nxt_gate_en = gate_en_ff;
        nxt_gate_level = gate_level_ff;
        nxt_power_down_n = power_down_n_ff;
        // status writes complete without error and change nothing
        // write lands on the completing access edge only
        if (access_done && pwrite && reg_hit(paddr, `CTRL_ADDR)) begin
            nxt_select = pwdata[`CTRL_SELECT_BIT];
            nxt_force = pwdata[`CTRL_FORCE_BIT];
            nxt_gate_en = pwdata[`CTRL_GATE_EN_BIT];
            nxt_gate_level = pwdata[`CTRL_GATE_LEVEL_BIT];
            nxt_power_down_n = pwdata[`CTRL_POWER_DOWN_N_BIT];
        end
    end

    // registers only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= 32'h0000_0000;
            select_ff <= `SELECT_RESET;
            force_ff <= `FORCE_RESET;
            gate_en_ff <= `GATE_EN_RESET;
            gate_level_ff <= `GATE_LEVEL_RESET;
            power_down_n_ff <= `POWER_DOWN_N_RESET;
        end else begin
            pready_ff <= nxt_pready;
            pslverr_ff <= nxt_pslverr;
            prdata_ff <= nxt_prdata;
            select_ff <= nxt_select;
            force_ff <= nxt_force;
            gate_en_ff <= nxt_gate_en;
            gate_level_ff <= nxt_gate_level;
            power_down_n_ff <= nxt_power_down_n;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // switchover sequencer

    logic force_d_ff, nxt_force_d, nxt_active, nxt_clk, force_rise;
    logic act_lvl, act_rise, act_fall, act_alive, new_rise;
    clock_switch_pkg::cycle_cnt_t cnt_ff, nxt_cnt;

    // one pass computes the next sequencer state and the internal clock
    always_comb begin
        act_lvl = pick(active_ff, lvl_a, lvl_b);
        act_rise = pick(active_ff, rise_a, rise_b);
        act_fall = pick(active_ff, fall_a, fall_b);
        act_alive = pick(active_ff, alive_a, alive_b);
        new_rise = pick(select_ff, rise_a, rise_b);
        // force acts on its edge only, so holding it high freezes the choice in run, not while parked
        force_rise = force_ff & ~force_d_ff;
        nxt_force_d = force_ff;
        nxt_state = state_ff;
        nxt_active = active_ff;
        nxt_cnt = cnt_ff;
        nxt_clk = clk_ff;
        if (force_rise) begin
            // low at once, a short pulse may be cut; restart on select
            nxt_clk = 1'b0;
            nxt_active = select_ff;
            nxt_cnt = '0;
            nxt_state = clock_switch_pkg::SW_PARK;
        end else begin
            unique case (state_ff)
                clock_switch_pkg::SW_RUN: begin
                    nxt_clk = act_lvl; // only the active input reaches the output
                    // while forced a select change waits until force is released
                    if (!force_ff && (select_ff != active_ff)) begin
                        nxt_cnt = '0;
                        nxt_state = clock_switch_pkg::SW_DRAIN;
                    end
                end
                clock_switch_pkg::SW_DRAIN: begin
                    // park on the old clock's fall; a dead old clock is not waited for
                    if (act_fall || !clk_ff || !act_alive || (cnt_ff == `DRAIN_MAX_CYCLES)) begin
                        nxt_clk = 1'b0;
                        nxt_active = select_ff;
                        nxt_cnt = '0;
                        nxt_state = clock_switch_pkg::SW_PARK;
                    end else begin
                        nxt_clk = act_lvl;
                        if (act_rise) begin
                            nxt_cnt = cnt_ff + 2'h1;
                        end
                    end
                end
                clock_switch_pkg::SW_PARK: begin
                    nxt_clk = 1'b0;
                    if (select_ff != active_ff) begin
                        // select moved again before restart: restart the count
                        nxt_active = select_ff;
                        nxt_cnt = '0;
                    end else if (new_rise) begin
                        if (cnt_ff == (`PARK_MAX_CYCLES - 2'h1)) begin
                            nxt_clk = 1'b1;
                            nxt_state = clock_switch_pkg::SW_RUN;
                        end else begin
                            nxt_cnt = cnt_ff + 2'h1;
                        end
                    end
                end
                default: begin
                    // unused state code: park low, then restart on the selected input
                    nxt_clk = 1'b0;
                    nxt_active = select_ff;
                    nxt_cnt = '0;
                    nxt_state = clock_switch_pkg::SW_PARK;
                end
            endcase
        end
    end

    // registers only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_ff <= clock_switch_pkg::SW_RUN;
            active_ff <= `SELECT_RESET;
            cnt_ff <= '0;
            clk_ff <= 1'b0;
            force_d_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            active_ff <= nxt_active;
            cnt_ff <= nxt_cnt;
            clk_ff <= nxt_clk;
            force_d_ff <= nxt_force_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // output pair: power-down over gating over the running clock

    logic out_p_ff, out_n_ff, nxt_out_p, nxt_out_n;

    // gating is not synchronised to the clock, so it can cut a pulse short
    always_comb begin
        // power-down first: both legs high whatever the gate says
        if (!power_down_n_ff) begin
            nxt_out_p = 1'b1;
            nxt_out_n = 1'b1;
        end else if (!gate_en_ff) begin
            nxt_out_p = gate_level_ff;
            nxt_out_n = ~gate_level_ff;
        end else begin
            nxt_out_p = clk_ff;
            nxt_out_n = ~clk_ff;
        end
    end

    // registers only; reset shows gate-enabled low clock
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_p_ff <= 1'b0;
            out_n_ff <= 1'b1;
        end else begin
            out_p_ff <= nxt_out_p;
            out_n_ff <= nxt_out_n;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // port drive

    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign clock_output_pair_p = out_p_ff;
    assign clock_output_pair_n = out_n_ff;

endmodule

/* File: tb/clock_switch_assertions.sv */
// checker for the clock selector: apb answer timing and output-pair rules
// assumes it sees only the top ports; mirrors the control word from apb writes
`timescale 1ns/10ps
`include "clock_switch_params.svh"

module clock_switch_assertions (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic clk_in_a,
    input wire logic clk_in_b,
    input wire logic clock_output_pair_p,
    input wire logic clock_output_pair_n
);
    // drain covers three old rises plus sync; resume adds three new rises
    localparam int DRAIN_LIM = 40;
    localparam int RESUME_LIM = 90;
    logic [4:0] ctl_ff;
    logic [4:0] nxt_ctl;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    ////////////////////////////////////////////////////////////////////////
    // shadow of the control word, updated at the completing access edge
    always_comb begin
        nxt_ctl = ctl_ff;
        if (psel && penable && pready && pwrite && paddr == `CTRL_ADDR) begin
            nxt_ctl = pwdata[4:0];
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctl_ff <= 5'h14;
        end else begin
            ctl_ff <= nxt_ctl;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    property p_ready_next;
        psel && !penable |=> pready;
    endproperty
    a_ready_next: assert property (p_ready_next) else $error("pready late");
    property p_ready_pulse;
        pready |=> !pready;
    endproperty
    a_ready_pulse: assert property (p_ready_pulse) else $error("pready held");
    property p_err_map;
        pready |-> pslverr == (paddr != `CTRL_ADDR && paddr != `STATUS_ADDR);
    endproperty
    a_err_map: assert property (p_err_map) else $error("pslverr wrong");
    // settled control word: two cycles past its last write
    property p_power_down;
        !ctl_ff[4] && $past(ctl_ff, 2) == ctl_ff |-> clock_output_pair_p && clock_output_pair_n;
    endproperty
    a_power_down: assert property (p_power_down) else $error("legs not high");
    property p_gate_level;
        ctl_ff[4] && !ctl_ff[2] && $past(ctl_ff, 2) == ctl_ff
            |-> clock_output_pair_p == ctl_ff[3] && clock_output_pair_n == !ctl_ff[3];
    endproperty
    a_gate_level: assert property (p_gate_level) else $error("gate level wrong");
    property p_force_low;
        ctl_ff[4] && ctl_ff[2] && $rose(ctl_ff[1]) |-> ##[0:3] !clock_output_pair_p;
    endproperty
    a_force_low: assert property (p_force_low) else $error("force not low");
    sequence s_switch;
        ctl_ff[4] && ctl_ff[2] && !ctl_ff[1] && ctl_ff[0] != $past(ctl_ff[0]);
    endsequence
    property p_drain;
        s_switch |-> ##[0:DRAIN_LIM] !clock_output_pair_p;
    endproperty
    a_drain: assert property (p_drain) else $error("no park on switch");
    property p_resume;
        s_switch |-> ##[1:RESUME_LIM] clock_output_pair_p;
    endproperty
    a_resume: assert property (p_resume) else $error("no restart");
    // with a settled control word every level of the true leg lasts two samples at least
    property p_no_runt;
        $past(ctl_ff, 2) == ctl_ff && $changed(clock_output_pair_p)
            |=> $stable(clock_output_pair_p);
    endproperty
    a_no_runt: assert property (p_no_runt) else $error("output runt");
    c_switch: cover property (s_switch);
    c_force: cover property (ctl_ff[4] && $rose(ctl_ff[1]));
    c_down: cover property (!ctl_ff[4] && clock_output_pair_p);
endmodule

bind clock_switch clock_switch_assertions u_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .clk_in_a(clk_in_a), .clk_in_b(clk_in_b), .clock_output_pair_p(clock_output_pair_p),
    .clock_output_pair_n(clock_output_pair_n)
);

/* File: tb/clock_source_model.sv */
// upstream clock source: free toggling while run is high
// assumes the bench sets run; a dead source loses swing and sits low
`timescale 1ns/10ps

module clock_source_model #(
    parameter real HALF_NS = 210.0
) (
    input wire logic run,
    output logic clk_out
);
    // own time base, unrelated in phase to pclk
    initial begin
        clk_out = 1'b0;
        forever begin
            #(HALF_NS);
            clk_out = run ? ~clk_out : 1'b0;
        end
    end
endmodule

/* File: tb/tb_top.sv */
// self-checking bench for the clock selector
// assumes apb zero-wait answer; sources a and b at about 8.4 and 10.2 pclk
`timescale 1ns/10ps
`include "clock_switch_params.svh"

module tb_top;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [`ADDR_W-1:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd_val;
    logic pready, pslverr, clk_in_a, clk_in_b, q_p, q_n, err_val;
    logic run_a = 1'b1, run_b = 1'b1;
    int err_total = 0, comparisons = 0;

    always #25 pclk = ~pclk;
    clock_source_model #(.HALF_NS(210.0)) src_a (.run(run_a), .clk_out(clk_in_a));
    clock_source_model #(.HALF_NS(255.0)) src_b (.run(run_b), .clk_out(clk_in_b));
    clock_switch dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .clk_in_a(clk_in_a), .clk_in_b(clk_in_b),
        .clock_output_pair_p(q_p), .clock_output_pair_n(q_n));

    ////////////////////////////////////////////////////////////////////////
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // one apb transfer; request held until pready is sampled high
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        int n;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd_val = prdata;
        err_val = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20) begin
            err_total++;
            tally_and_finish();
        end
        @(posedge pclk);
    endtask
    // rising edges of the true leg over 200 pclk, judged against a band
    task automatic rate(input int lo, input int hi);
        int c;
        logic last;
        repeat (100) @(posedge pclk);
        c = 0;
        last = q_p;
        repeat (200) begin
            @(posedge pclk);
            if (last === 1'b0 && q_p === 1'b1) c++;
            last = q_p;
        end
        check({31'h0, c >= lo && c <= hi}, 32'h1);
    endtask
    // gate-off goes out just after a fall, so it lands inside the low phase
    task automatic gate_after_fall(input logic [31:0] wd);
        int n;
        logic last;
        n = 0;
        do begin
            last = q_p;
            @(posedge pclk);
            n++;
        end while (!(last === 1'b1 && q_p === 1'b0) && n < 40);
        if (!(last === 1'b1 && q_p === 1'b0)) begin
            err_total++;
            tally_and_finish();
        end
        apb(1, `CTRL_ADDR, wd);
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic t_regs();
        apb(0, `CTRL_ADDR, 0);
        check(rd_val, 32'h14);
        apb(1, 12'h008, 32'hFF);
        check({31'h0, err_val}, 32'h1);
        apb(0, 12'h008, 0);
        check({rd_val[30:0], err_val}, 32'h1);
        apb(1, `STATUS_ADDR, 32'h0);
        apb(0, `CTRL_ADDR, 0);
        check(rd_val, 32'h14);
        apb(0, `STATUS_ADDR, 0);
        check({rd_val[31:6], rd_val[5:4], rd_val[0]}, {26'h0, 3'b110});
    endtask
    task automatic t_switch();
        apb(1, `CTRL_ADDR, 32'h15);
        rate(18, 21);
        apb(0, `STATUS_ADDR, 0);
        check({31'h0, rd_val[0]}, 32'h1);
        apb(1, `CTRL_ADDR, 32'h14);
        rate(22, 25);
    endtask
    // selected source dies, then force is held while it is repaired
    task automatic t_force();
        run_a <= 1'b0;
        repeat (40) @(posedge pclk);
        apb(0, `STATUS_ADDR, 0);
        check({31'h0, rd_val[4]}, 32'h0);
        apb(1, `CTRL_ADDR, 32'h17);
        rate(18, 21);
        run_a <= 1'b1;
        apb(1, `CTRL_ADDR, 32'h16);
        rate(18, 21);
        apb(1, `CTRL_ADDR, 32'h15);
        apb(1, `CTRL_ADDR, 32'h14);
        apb(1, `CTRL_ADDR, 32'h16);
        rate(22, 25);
        run_b <= 1'b0;
        rate(22, 25);
        run_b <= 1'b1;
        apb(1, `CTRL_ADDR, 32'h14);
    endtask
    // gate off, power down and back, in the recommended order
    task automatic t_gate();
        gate_after_fall(32'h18);
        repeat (4) @(posedge pclk);
        check({30'h0, q_p, q_n}, 32'h2);
        apb(1, `CTRL_ADDR, 32'h10);
        repeat (4) @(posedge pclk);
        check({30'h0, q_p, q_n}, 32'h1);
        apb(1, `CTRL_ADDR, 32'h08);
        repeat (4) @(posedge pclk);
        check({30'h0, q_p, q_n}, 32'h3);
        apb(1, `CTRL_ADDR, 32'h18);
        repeat (4) @(posedge pclk);
        check({30'h0, q_p, q_n}, 32'h2);
        apb(1, `CTRL_ADDR, 32'h14);
        rate(22, 25);
    endtask

    initial begin
        repeat (2) @(posedge pclk);
        check({30'h0, q_p, q_n}, 32'h1);
        @(posedge pclk);
        presetn <= 1'b1;
        repeat (60) @(posedge pclk);
        t_regs();
        t_switch();
        t_force();
        t_gate();
        tally_and_finish();
    end
endmodule
